// [inc/sat_pkg.sv]
// Package for the serial transmitter: register offsets, field positions, reset values and carrier types.
// Assumes a single 10 MHz system clock and a simple strobe register port.
package sat_pkg;

  localparam int unsigned SAT_ADDR_W = 4;

  // Register offsets.
  localparam logic [3:0] SAT_OFF_TX_STATUS_CONTROL = 4'h0;
  localparam logic [3:0] SAT_OFF_RX_STATUS_CONTROL = 4'h1;
  localparam logic [3:0] SAT_OFF_BAUD_RATE_CONTROL = 4'h2;
  localparam logic [3:0] SAT_OFF_BAUD_DIVISOR_LOW = 4'h3;
  localparam logic [3:0] SAT_OFF_BAUD_DIVISOR_HIGH = 4'h4;
  localparam logic [3:0] SAT_OFF_TX_BUFFER = 4'h5;
  localparam logic [3:0] SAT_OFF_IRQ_ENABLE = 4'h6;
  localparam logic [3:0] SAT_OFF_IRQ_FLAGS = 4'h7;

  // Field positions in tx_status_control.
  localparam int unsigned SAT_TXC_CLOCK_SOURCE_MASTER = 7;
  localparam int unsigned SAT_TXC_NINE_BIT_TX = 6;
  localparam int unsigned SAT_TXC_TX_ENABLE = 5;
  localparam int unsigned SAT_TXC_SYNC_SELECT = 4;
  localparam int unsigned SAT_TXC_BAUD_HIGH_SPEED = 2;
  localparam int unsigned SAT_TXC_TX_SHIFT_EMPTY = 1;
  localparam int unsigned SAT_TXC_NINTH_TX_BIT = 0;

  // Field positions in rx_status_control.
  localparam int unsigned SAT_RXC_PORT_ENABLE = 7;
  localparam int unsigned SAT_RXC_SINGLE_RX_ENABLE = 5;
  localparam int unsigned SAT_RXC_CONTINUOUS_RX_ENABLE = 4;

  // Field positions in baud_rate_control.
  localparam int unsigned SAT_BRC_AUTOBAUD_OVERFLOW = 7;
  localparam int unsigned SAT_BRC_RX_IDLE_FLAG = 6;
  localparam int unsigned SAT_BRC_POLARITY_SELECT = 4;
  localparam int unsigned SAT_BRC_BAUD_GEN_WIDE = 3;
  localparam int unsigned SAT_BRC_WAKEUP_ENABLE = 1;
  localparam int unsigned SAT_BRC_AUTOBAUD_ENABLE = 0;
  localparam logic [7:0] SAT_BRC_WRITE_MASK = 8'h1b;

  // Interrupt enable and flag positions.
  localparam int unsigned SAT_IRQ_TX = 4;
  localparam int unsigned SAT_IRQ_RX = 5;

  // Reset values.
  localparam logic [7:0] SAT_RST_TX_STATUS_CONTROL = 8'h02;
  localparam logic [7:0] SAT_RST_RX_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] SAT_RST_BAUD_RATE_CONTROL = 8'h00;
  localparam logic [7:0] SAT_RST_BYTE = 8'h00;

  // Frame and flag timing counts.
  localparam logic [3:0] SAT_DATA_BITS_8 = 4'h8;
  localparam logic [3:0] SAT_DATA_BITS_9 = 4'h9;
  localparam logic [1:0] SAT_FLAG_SETTLE_CYCLES = 2'h2;

  typedef struct packed {
    logic [7:0] addr_pad;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sat_bus_req_type;

  typedef struct packed {
    logic clk_o;
    logic clk_oe;
    logic dat_o;
    logic dat_oe;
  } sat_pins_type;

  typedef enum logic [1:0] {
    SAT_IDLE,
    SAT_START,
    SAT_DATA,
    SAT_STOP
  } sat_state_type;

endpackage

// [design/sat_tx.sv]
// Serial transmitter with asynchronous frames and synchronous master transmit.
// Assumes a single-clock register port; receive-side status inputs are synchronised inside, pin inputs are unused.
// Operation
// - Idle mark, start, 8 or 9 data, stop
// - Each async bit lasts one baud period, sync bit two
// - Data shifted least significant bit first
// - Shared format and rate, no hardware parity
// - Async needs tx enable, async, port enable
// - Empty flag sets with tx enable
// - Buffer moves to shifter when free
// - Async polarity inverts idle and data
// - Empty flag clear only when buffer waits
// - Flag valid from second cycle after write
// - Flag ignores irq enable, request gated
// - Wake-up sets receive flag, then self-clears
// - Sync mode: no start or stop bits
// - Sync master select, receive enables off
// - Master drives clock, one per bit
// - Data changes on leading clock edge
// - Sync polarity sets clock idle level
// - Sync data on data pin, buffered waits
`timescale 1ns/10ps
`default_nettype none

module sat_tx
  import sat_pkg::*;
(
  // Clock and reset.
  input wire logic SYS_CLK_I,
  input wire logic ARST_N_I,
  // Register port.
  input wire logic [3:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  // Status inputs from the receive side.
  input wire logic AUTOBAUD_OVF_I,
  input wire logic RX_IDLE_I,
  input wire logic RX_WAKE_EDGE_I,
  // Pins.
  input wire logic TX_CLOCK_PIN_I,
  output logic TX_CLOCK_PIN_O,
  output logic TX_CLOCK_PIN_OE_O,
  input wire logic RX_DATA_PIN_I,
  output logic RX_DATA_PIN_O,
  output logic RX_DATA_PIN_OE_O,
  // Interrupt request towards the core.
  output logic TX_IRQ_O
);

  function automatic logic [15:0] sat_reload(input logic wide, input logic [15:0] div);
    sat_reload = wide ? div : {8'h00, div[7:0]};
  endfunction

  logic [7:0] txc_r, rxc_r, brc_r, div_lo_r, div_hi_r, tx_buffer_r, irq_en_r;
  logic [8:0] tx_shift_reg_r;
  logic buf_full_r, rx_flag_r, ovf_s1_r, ovf_s2_r, idle_s1_r, idle_s2_r, wk_s1_r, wk_s2_r, wk_d_r;
  logic [15:0] brg_cnt_r;
  logic [3:0] bit_cnt_r;
  logic half_r;
  logic [1:0] settle_r;
  logic empty_view_r;
  logic [7:0] rdata_r;
  sat_state_type state_r;
  sat_pins_type pins;

  logic port_en, tx_en, sync_mode, master, pol, nine, async_act, sync_act, active, tick, load;
  logic wake_rise, flag_live;

  assign port_en = rxc_r[SAT_RXC_PORT_ENABLE];
  assign tx_en = txc_r[SAT_TXC_TX_ENABLE];
  assign sync_mode = txc_r[SAT_TXC_SYNC_SELECT];
  assign master = txc_r[SAT_TXC_CLOCK_SOURCE_MASTER];
  assign pol = brc_r[SAT_BRC_POLARITY_SELECT];
  assign nine = txc_r[SAT_TXC_NINE_BIT_TX];
  assign async_act = tx_en & ~sync_mode & port_en;
  assign sync_act = tx_en & sync_mode & master & port_en & ~rxc_r[SAT_RXC_SINGLE_RX_ENABLE]
    & ~rxc_r[SAT_RXC_CONTINUOUS_RX_ENABLE];
  assign active = async_act | sync_act;
  assign tick = (brg_cnt_r == 16'h0000);
  assign load = active & buf_full_r & (state_r == SAT_IDLE);
  assign wake_rise = wk_s2_r & ~wk_d_r;
  // Hardware state view of the empty flag; the register copy lags by design.
  assign flag_live = tx_en & ~buf_full_r;

  // Input synchronisers.
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ovf_s1_r <= 1'b0;
      ovf_s2_r <= 1'b0;
      idle_s1_r <= 1'b1;
      idle_s2_r <= 1'b1;
      wk_s1_r <= 1'b0;
      wk_s2_r <= 1'b0;
      wk_d_r <= 1'b0;
    end else begin
      ovf_s1_r <= AUTOBAUD_OVF_I;
      ovf_s2_r <= ovf_s1_r;
      idle_s1_r <= RX_IDLE_I;
      idle_s2_r <= idle_s1_r;
      wk_s1_r <= RX_WAKE_EDGE_I;
      wk_s2_r <= wk_s1_r;
      wk_d_r <= wk_s2_r;
    end
  end

  // Control registers.
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      txc_r <= SAT_RST_TX_STATUS_CONTROL;
      rxc_r <= SAT_RST_RX_STATUS_CONTROL;
      brc_r <= SAT_RST_BAUD_RATE_CONTROL;
      div_lo_r <= SAT_RST_BYTE;
      div_hi_r <= SAT_RST_BYTE;
      irq_en_r <= SAT_RST_BYTE;
    end else begin
      if (WR_I && ADDR_I == SAT_OFF_TX_STATUS_CONTROL) begin
        txc_r <= {WDATA_I[7:2], 1'b0, WDATA_I[0]};
      end
      if (WR_I && ADDR_I == SAT_OFF_RX_STATUS_CONTROL) begin
        rxc_r <= WDATA_I;
      end
      if (WR_I && ADDR_I == SAT_OFF_BAUD_DIVISOR_LOW) begin
        div_lo_r <= WDATA_I;
      end
      if (WR_I && ADDR_I == SAT_OFF_BAUD_DIVISOR_HIGH) begin
        div_hi_r <= WDATA_I;
      end
      if (WR_I && ADDR_I == SAT_OFF_IRQ_ENABLE) begin
        irq_en_r <= WDATA_I;
      end
      if (WR_I && ADDR_I == SAT_OFF_BAUD_RATE_CONTROL) begin
        brc_r <= WDATA_I & SAT_BRC_WRITE_MASK;
      end else if (wake_rise && brc_r[SAT_BRC_WAKEUP_ENABLE] && !sync_mode) begin
        brc_r[SAT_BRC_WAKEUP_ENABLE] <= 1'b0;
      end
    end
  end

  // Receive flag raised by a wake-up event; the set wins over a software clear.
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rx_flag_r <= 1'b0;
    end else if (wake_rise && brc_r[SAT_BRC_WAKEUP_ENABLE] && !sync_mode) begin
      rx_flag_r <= 1'b1;
    end else if (WR_I && ADDR_I == SAT_OFF_IRQ_FLAGS && !WDATA_I[SAT_IRQ_RX]) begin
      rx_flag_r <= 1'b0;
    end
  end

  // Transmit buffer; a disabled transmitter drops any queued byte.
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      tx_buffer_r <= SAT_RST_BYTE;
      buf_full_r <= 1'b0;
    end else if (!active) begin
      buf_full_r <= 1'b0;
    end else if (WR_I && ADDR_I == SAT_OFF_TX_BUFFER) begin
      tx_buffer_r <= WDATA_I;
      buf_full_r <= 1'b1;
    end else if (load) begin
      buf_full_r <= 1'b0;
    end
  end

  // Empty flag register copy updates two cycles after a buffer write.
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      settle_r <= 2'h0;
      empty_view_r <= 1'b0;
    end else begin
      if (WR_I && ADDR_I == SAT_OFF_TX_BUFFER) begin
        settle_r <= SAT_FLAG_SETTLE_CYCLES;
      end else if (settle_r != 2'h0) begin
        settle_r <= settle_r - 2'h1;
      end
      if (settle_r <= 2'h1) begin
        empty_view_r <= flag_live;
      end
    end
  end

  // Baud generator; in sync mode each baud tick is one clock half period.
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      brg_cnt_r <= 16'h0000;
    end else if (state_r == SAT_IDLE || tick) begin
      brg_cnt_r <= sat_reload(brc_r[SAT_BRC_BAUD_GEN_WIDE], {div_hi_r, div_lo_r});
    end else begin
      brg_cnt_r <= brg_cnt_r - 16'h0001;
    end
  end

  // Frame sequencer.
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state_r <= SAT_IDLE;
      tx_shift_reg_r <= 9'h1ff;
      bit_cnt_r <= 4'h0;
      half_r <= 1'b0;
    end else if (!active) begin
      state_r <= SAT_IDLE;
      half_r <= 1'b0;
    end else begin
      unique case (state_r)
        SAT_IDLE: begin
          if (load) begin
            tx_shift_reg_r <= {txc_r[SAT_TXC_NINTH_TX_BIT], tx_buffer_r};
            bit_cnt_r <= nine ? SAT_DATA_BITS_9 : SAT_DATA_BITS_8;
            half_r <= 1'b0;
            state_r <= sync_mode ? SAT_DATA : SAT_START;
          end
        end
        SAT_START: begin
          if (tick) begin
            state_r <= SAT_DATA;
          end
        end
        SAT_DATA: begin
          if (tick) begin
            half_r <= ~half_r;
            if (!sync_mode || half_r) begin
              tx_shift_reg_r <= {1'b1, tx_shift_reg_r[8:1]};
              bit_cnt_r <= bit_cnt_r - 4'h1;
              if (bit_cnt_r == 4'h1) begin
                state_r <= sync_mode ? SAT_IDLE : SAT_STOP;
              end
            end
          end
        end
        SAT_STOP: begin
          if (tick) begin
            state_r <= SAT_IDLE;
          end
        end
      endcase
    end
  end

  // Pin drive.
  always_comb begin
    pins.clk_o = 1'b1 ^ pol;
    pins.clk_oe = port_en;
    pins.dat_o = 1'b0;
    pins.dat_oe = 1'b0;
    if (sync_mode) begin
      pins.clk_oe = port_en & master;
      pins.clk_o = pol ^ ((state_r == SAT_DATA) & ~half_r);
      pins.dat_o = tx_shift_reg_r[0];
      pins.dat_oe = sync_act;
    end else if (state_r == SAT_START) begin
      pins.clk_o = pol;
    end else if (state_r == SAT_DATA) begin
      pins.clk_o = tx_shift_reg_r[0] ^ pol;
    end
  end

  assign TX_CLOCK_PIN_O = pins.clk_o;
  assign TX_CLOCK_PIN_OE_O = pins.clk_oe;
  assign RX_DATA_PIN_O = pins.dat_o;
  assign RX_DATA_PIN_OE_O = pins.dat_oe;
  assign TX_IRQ_O = empty_view_r & irq_en_r[SAT_IRQ_TX];

  // Read data, valid in the cycle after the strobe. The flags register ignores software writes to the empty flag.
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rdata_r <= 8'h00;
    end else if (RD_I) begin
      unique case (ADDR_I)
        SAT_OFF_TX_STATUS_CONTROL: rdata_r <= {txc_r[7:2], (state_r == SAT_IDLE), txc_r[0]};
        SAT_OFF_RX_STATUS_CONTROL: rdata_r <= rxc_r;
        SAT_OFF_BAUD_RATE_CONTROL: rdata_r <= {ovf_s2_r & ~sync_mode, idle_s2_r, brc_r[5:0]};
        SAT_OFF_BAUD_DIVISOR_LOW: rdata_r <= div_lo_r;
        SAT_OFF_BAUD_DIVISOR_HIGH: rdata_r <= div_hi_r;
        SAT_OFF_TX_BUFFER: rdata_r <= tx_buffer_r;
        SAT_OFF_IRQ_ENABLE: rdata_r <= irq_en_r;
        SAT_OFF_IRQ_FLAGS: rdata_r <= {2'h0, rx_flag_r, empty_view_r, 4'h0};
        default: rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign RDATA_O = rdata_r;

endmodule

`default_nettype wire

// [test/sat_tx_properties.sv]
// Port checker for the serial transmitter, bound to the top module.
// Assumes configuration changes only through register port writes.
`timescale 1ns/10ps
`default_nettype none
module sat_tx_properties (
  // Clock, reset and register writes.
  input wire logic SYS_CLK_I,
  input wire logic ARST_N_I,
  input wire logic [3:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  // Pin and request outputs.
  input wire logic TX_CLOCK_PIN_O,
  input wire logic TX_CLOCK_PIN_OE_O,
  input wire logic RX_DATA_PIN_OE_O,
  input wire logic TX_IRQ_O
);
  logic [7:0] sh_r [8];
  logic [16:0] run_r;
  logic [16:0] bt;
  logic pin_q, pe, tx_enable, sy, ms, rxen, pol, ie, aon, smt, smr, buf_wr;
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      sh_r <= '{default: 8'h00};
      pin_q <= 1'b1;
      run_r <= 17'h0;
    end else begin
      if (WR_I && !ADDR_I[3]) begin
        sh_r[ADDR_I[2:0]] <= WDATA_I;
      end
      pin_q <= TX_CLOCK_PIN_O;
      run_r <= (TX_CLOCK_PIN_O != pin_q) ? 17'h1 : run_r + 17'h1;
    end
  end
  assign ms = sh_r[0][7];
  assign tx_enable = sh_r[0][5];
  assign sy = sh_r[0][4];
  assign pe = sh_r[1][7];
  assign rxen = |sh_r[1][5:4];
  assign pol = sh_r[2][4];
  assign ie = sh_r[6][4];
  assign bt = (sh_r[2][3] ? {1'b0, sh_r[4], sh_r[3]} : {9'h0, sh_r[3]}) + 17'h1;
  assign aon = pe && tx_enable && !sy;
  assign smt = pe && sy && ms && !rxen;
  assign smr = pe && sy && ms && rxen;
  assign buf_wr = WR_I && ADDR_I == 4'h5;
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!ARST_N_I);
  sequence s_quiet;
    (pe && !tx_enable && (!sy || ms) && $stable(pol) && $stable(sy))[*2];
  endsequence
  sequence s_enable;
    $rose(tx_enable) && ie;
  endsequence
  oe_follow_a: assert property (TX_CLOCK_PIN_OE_O == (pe && (!sy || ms)))
    else $error("clock pin enable wrong");
  data_oe_a: assert property (RX_DATA_PIN_OE_O |-> smt || $past(smt))
    else $error("data pin driven outside master transmit");
  rx_quiet_a: assert property (smr [*2] |-> !RX_DATA_PIN_OE_O)
    else $error("data pin driven while receiving");
  irq_gate_a: assert property (TX_IRQ_O |-> ie)
    else $error("request without enable");
  quiet_level_a: assert property (s_quiet |-> TX_CLOCK_PIN_O == (sy ? pol : !pol))
    else $error("idle level wrong");
  // Only space runs are timed: a mark run may merge stop bits with idle time.
  space_len_a: assert property (aon && $past(aon) && $stable(pol) && TX_CLOCK_PIN_O != pin_q
    && TX_CLOCK_PIN_O != pol |-> run_r % bt == 17'h0)
    else $error("space run not whole bits");
  flag_fall_a: assert property ($fell(TX_IRQ_O) && ie && $past(ie) && tx_enable && $past(tx_enable)
    |-> $past(buf_wr, 2) || $past(buf_wr, 3))
    else $error("empty flag fell at wrong time");
  flag_on_a: assert property (s_enable |-> ##[0:2] TX_IRQ_O)
    else $error("empty flag not set on enable");
endmodule
bind sat_tx sat_tx_properties sat_tx_properties_i (.SYS_CLK_I, .ARST_N_I, .ADDR_I, .WDATA_I, .WR_I,
  .TX_CLOCK_PIN_O, .TX_CLOCK_PIN_OE_O, .RX_DATA_PIN_OE_O, .TX_IRQ_O);
`default_nettype wire

// [test/sat_link_model.sv]
// Far-side model: decodes asynchronous frames and synchronous master bytes.
// Samples on falling clock edges, away from the design's launch edge.
`timescale 1ns/10ps
`default_nettype none
module sat_link_model (
  // Clock and pins.
  input wire logic clk_i,
  input wire logic line_i,
  input wire logic sdat_i,
  // Format set by the bench.
  input wire logic pol_i,
  input wire logic sync_i,
  input wire logic nine_i,
  input wire logic [31:0] bt_i,
  // Decoded characters.
  output logic [8:0] word_o,
  output logic stop_ok_o,
  output int words_o,
  output int edges_o
);
  logic [8:0] w;
  logic [8:0] sw = 9'h0;
  logic cq = 1'b0;
  int sk = 0;
  initial begin
    words_o = 0;
    edges_o = 0;
    forever begin
      @(negedge clk_i);
      if (!sync_i && line_i == pol_i) begin
        w = 9'h0;
        repeat (bt_i / 2) @(negedge clk_i);
        for (int k = 0; k < (nine_i ? 9 : 8); k++) begin
          repeat (bt_i) @(negedge clk_i);
          w[k] = line_i ^ pol_i;
        end
        repeat (bt_i) @(negedge clk_i);
        stop_ok_o = line_i ^ pol_i;
        word_o = w;
        words_o++;
      end
    end
  end
  always @(negedge clk_i) begin
    if (!sync_i) begin
      sk = 0;
      sw = 9'h0;
    end else if (!cq && (line_i ^ pol_i)) begin
      edges_o++;
    end else if (cq && !(line_i ^ pol_i)) begin
      sw[sk] = sdat_i;
      sk++;
      if (sk == 8 + nine_i) begin
        word_o = sw;
        words_o++;
        sk = 0;
      end
    end
    // Outside sync mode cq is forced low by sync_i, so the mode switch is seen as an edge only if the clock is off its idle level.
    cq = sync_i && (line_i ^ pol_i);
  end
endmodule
`default_nettype wire

// [test/sat_tx_tb.sv]
// Bench for the serial transmitter: register tasks and frame checks.
// Assumes the link model decodes every frame on the resolved pins.
`timescale 1ns/10ps
`default_nettype none
module sat_tx_tb;
  logic clk, rst_n, wr, rd, ovf, ridle, wake, cko, ckoe, dto, dtoe, irq, pol, sy, nine, stop_ok;
  logic [3:0] addr;
  logic [7:0] wdata, rdata;
  logic [8:0] word;
  wire logic ckp, dtp;
  int bt, e, n_errors, check_count, words, edges;
  assign ckp = ckoe ? cko : 1'b1;
  assign dtp = dtoe ? dto : 1'b1;
  sat_tx sat_tx_i (.SYS_CLK_I(clk), .ARST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdata), .AUTOBAUD_OVF_I(ovf), .RX_IDLE_I(ridle), .RX_WAKE_EDGE_I(wake),
    .TX_CLOCK_PIN_I(ckp), .TX_CLOCK_PIN_O(cko), .TX_CLOCK_PIN_OE_O(ckoe), .RX_DATA_PIN_I(dtp),
    .RX_DATA_PIN_O(dto), .RX_DATA_PIN_OE_O(dtoe), .TX_IRQ_O(irq));
  sat_link_model sat_link_model_i (.clk_i(clk), .line_i(ckp), .sdat_i(dtp), .pol_i(pol), .sync_i(sy),
    .nine_i(nine), .bt_i(bt), .word_o(word), .stop_ok_o(stop_ok), .words_o(words), .edges_o(edges));
  task chk(input logic [8:0] got, input logic [8:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    {wr, addr, wdata} <= {1'b1, a, d};
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] m);
    @(posedge clk);
    {rd, addr} <= {1'b1, a};
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk({1'b0, rdata & m}, {1'b0, exp});
  endtask
  task wait_words(input int n);
    for (int i = 0; i < 20000 && words < n; i++) @(posedge clk);
    if (words < n) n_errors++;
  endtask
  task close_out();
    $display("%0d checks, %0d mismatches", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    close_out();
  end
  initial begin
    {wr, rd, ovf, wake, rst_n, pol, sy, nine, addr, wdata} = '0;
    ridle = 1'b1;
    bt = 4;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(4'h0, 8'h02, 8'hff);
    rd_reg(4'h2, 8'h40, 8'hff);
    rd_reg(4'hf, 8'h00, 8'hff);
    $display("test reset done");
    ovf <= 1'b1;
    wr_reg(4'h2, 8'hff);
    rd_reg(4'h2, 8'hdb, 8'hff);
    wr_reg(4'h2, 8'h02);
    wake <= 1'b1;
    repeat (4) @(posedge clk);
    rd_reg(4'h7, 8'h20, 8'h20);
    rd_reg(4'h2, 8'hc0, 8'hff);
    wr_reg(4'h7, 8'h00);
    rd_reg(4'h7, 8'h00, 8'h20);
    $display("test status done");
    {ovf, wake} <= 2'b00;
    wr_reg(4'h3, 8'h03);
    wr_reg(4'h4, 8'hff);
    wr_reg(4'h6, 8'h10);
    wr_reg(4'h1, 8'h80);
    wr_reg(4'h0, 8'h20);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({8'h0, irq}, 9'h1);
    wr_reg(4'h5, 8'ha5);
    wr_reg(4'h5, 8'h3c);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({8'h0, irq}, 9'h0);
    wait_words(1);
    chk(word, 9'h0a5);
    wait_words(2);
    chk(word, 9'h03c);
    chk({8'h0, stop_ok}, 9'h1);
    $display("test async done");
    wr_reg(4'h4, 8'h01);
    wr_reg(4'h2, 8'h18);
    pol <= 1'b1;
    bt <= 260;
    wr_reg(4'h0, 8'h61);
    nine <= 1'b1;
    wr_reg(4'h5, 8'h5a);
    wait_words(3);
    chk(word, 9'h15a);
    $display("test wide done");
    wr_reg(4'h0, 8'h00);
    wr_reg(4'h5, 8'h77);
    repeat (3000) @(posedge clk);
    chk(words[8:0], 9'h3);
    $display("test disabled done");
    wr_reg(4'h2, 8'h00);
    {pol, nine} <= 2'b00;
    bt <= 4;
    wr_reg(4'h0, 8'hb0);
    sy <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      wr_reg(4'h2, {3'h0, p[0], 4'h0});
      pol <= p[0];
      e = edges;
      wr_reg(4'h5, 8'hc3);
      wait_words(4 + p);
      chk(word, 9'h0c3);
      chk(edges[8:0] - e[8:0], 9'h8);
    end
    wr_reg(4'h6, 8'h00);
    rd_reg(4'h7, 8'h10, 8'h10);
    wr_reg(4'h1, 8'hb0);
    repeat (3) @(posedge clk);
    chk({8'h0, dtoe}, 9'h0);
    $display("test sync done");
    close_out();
  end
endmodule
`default_nettype wire
